// *** pkg/utx_pkg.sv ***
// Constants, types and frame-building functions shared by the transmitter files.
package utx_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int CTRL_W = 5;
  localparam int ADDR_W = 4;
  localparam int REG_W = 32;
  localparam int FRAME_W = 12;
  localparam int HALF_W = 5;
  localparam int SUB_W = 3;
  localparam int INT_W = 2;
  localparam int FLAG_W = 4;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 4'hC;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 2'h0;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_PAR_EVEN = 0;
  localparam int CTRL_LEN_LO = 1;
  localparam int CTRL_LEN_HI = 2;
  localparam int CTRL_STOP_SEL = 3;
  localparam int CTRL_PAR_INH = 4;
  localparam int FLG_HBE = 0;
  localparam int FLG_SHIFT_EMPTY = 1;
  localparam int FLG_BUSY = 2;
  localparam int FLG_REQ = 3;
  localparam int INT_HBE = 0;
  localparam int INT_DONE = 1;

  // ---------------------------------------------------------------------------
  // Timing: sixteen transmit-clock ticks per bit, counted in half bits
  // ---------------------------------------------------------------------------
  localparam int TICKS_PER_BIT = 16;
  localparam int HALVES_PER_BIT = 2;
  localparam int TICKS_PER_HALF = TICKS_PER_BIT / HALVES_PER_BIT;
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(TICKS_PER_HALF - 1);
  localparam int MIN_LEN = 5;
  localparam int STOP_HALVES_ONE = 2;
  localparam int STOP_HALVES_ONE_HALF = 3;
  localparam int STOP_HALVES_TWO = 4;

  typedef enum logic [1:0] {
    UTX_IDLE = 2'b01,
    UTX_SEND = 2'b10
  } utx_state_type;

  // ---------------------------------------------------------------------------
  // Frame decoding
  // ---------------------------------------------------------------------------
  function automatic int utx_len(input logic [CTRL_W-1:0] ctrl);
    return MIN_LEN + int'({ctrl[CTRL_LEN_HI], ctrl[CTRL_LEN_LO]});
  endfunction

  // Bit 0 goes out first: start, data LSB first, optional parity, then ones.
  function automatic logic [FRAME_W-1:0] utx_frame(input logic [DATA_W-1:0] d, input logic [CTRL_W-1:0] ctrl);
    logic [FRAME_W-1:0] f;
    logic [DATA_W-1:0] m;
    logic par;
    int n;
    n = utx_len(ctrl);
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = (i < n) ? d[i] : 1'b0;
    end
    par = (^m) ^ ~ctrl[CTRL_PAR_EVEN];
    f = {FRAME_W{1'b1}};
    f[0] = 1'b0;
    for (int j = 1; j < FRAME_W; j++) begin
      if (j <= n) begin
        f[j] = m[j-1];
      end else if (j == n + 1 && !ctrl[CTRL_PAR_INH]) begin
        f[j] = par;
      end
    end
    return f;
  endfunction

  function automatic logic [HALF_W-1:0] utx_halves(input logic [CTRL_W-1:0] ctrl);
    int n;
    int stops;
    n = utx_len(ctrl);
    if (!ctrl[CTRL_STOP_SEL]) begin
      stops = STOP_HALVES_ONE;
    end else if (n == MIN_LEN) begin
      stops = STOP_HALVES_ONE_HALF;
    end else begin
      stops = STOP_HALVES_TWO;
    end
    return HALF_W'(HALVES_PER_BIT * (1 + n + (ctrl[CTRL_PAR_INH] ? 0 : 1)) + stops);
  endfunction

endpackage

// *** design/utx_shifter.sv ***
// Transmit shift register that walks one frame out in half-bit steps.
module utx_shifter
  import utx_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic clear, // Master clear, aborts any frame.
  input wire logic tick, // One-cycle pulse per rising edge of the sixteen-times clock.
  input wire logic load, // Start a frame on this tick.
  input wire logic [utx_pkg::FRAME_W-1:0] frame_in, // Frame bits, first bit in bit 0.
  input wire logic [utx_pkg::HALF_W-1:0] halves_in, // Frame length in half bits.
  output logic busy, // Frame in progress.
  output logic ending, // Last tick position of the frame.
  output logic line // Serial level to drive.
);
  import utx_pkg::*;

  utx_state_type state_q, state_d;
  logic [FRAME_W-1:0] frame_q, frame_d;
  logic [HALF_W-1:0] halves_q, halves_d;
  logic [HALF_W-1:0] half_q, half_d;
  logic [SUB_W-1:0] sub_q, sub_d;

  assign busy = (state_q == UTX_SEND);
  assign ending = busy && (half_q == halves_q - HALF_W'(1)) && (sub_q == SUB_LAST);
  assign line = busy ? frame_q[half_q[HALF_W-1:1]] : 1'b1;

  always_comb begin
    state_d = state_q;
    frame_d = frame_q;
    halves_d = halves_q;
    half_d = half_q;
    sub_d = sub_q;
    case (state_q)
      UTX_IDLE: begin
        if (tick && load) begin
          state_d = UTX_SEND;
          frame_d = frame_in;
          halves_d = halves_in;
          half_d = '0;
          sub_d = '0;
        end
      end
      UTX_SEND: begin
        if (tick) begin
          if (ending && load) begin
            frame_d = frame_in;
            halves_d = halves_in;
            half_d = '0;
            sub_d = '0;
          end else if (ending) begin
            state_d = UTX_IDLE;
          end else if (sub_q == SUB_LAST) begin
            sub_d = '0;
            half_d = half_q + HALF_W'(1);
          end else begin
            sub_d = sub_q + SUB_W'(1);
          end
        end
      end
      default: begin
        state_d = UTX_IDLE;
      end
    endcase
    if (clear) begin
      state_d = UTX_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= UTX_IDLE;
      frame_q <= '1;
      halves_q <= '0;
      half_q <= '0;
      sub_q <= '0;
    end else begin
      state_q <= state_d;
      frame_q <= frame_d;
      halves_q <= halves_d;
      half_q <= half_d;
      sub_q <= sub_d;
    end
  end

  property p_start_low;
    @(posedge clk) disable iff (!rst_n)
    tick && load && !clear && (!busy || ending) |=> busy && !line && half_q == '0;
  endproperty
  a_start_low: assert property (p_start_low) else $error("frame did not open with a low start bit");

  property p_tick_paced;
    @(posedge clk) disable iff (!rst_n)
    busy && !tick && !clear |=> $stable(half_q) && $stable(sub_q);
  endproperty
  a_tick_paced: assert property (p_tick_paced) else $error("bit timer moved without a transmit tick");

endmodule

// *** design/utx_top.sv ***
// Transmit half of a pin-programmed serial transceiver with its control word.
//
// What this block does
// - While the load strobe is low, copy the character inputs into the holding buffer.
// - A rising load strobe requests a move into the shift register.
// - A move waits for the running character; characters then go back to back.
// - Shifter-empty rises only after the last stop bit has gone out, or on master clear.
// - Start, data and stop bits go out in turn on one serial line.
// - Character inputs above the programmed length are ignored.
// - While control load is high, capture the five control-word inputs.
// - Parity inhibit drops the parity bit and holds the parity error output low.
// - Stop select gives 1.5 stops for five bits, 2 otherwise; else one.
// - Length select decodes to 5, 6, 7 or 8 data bits.
// - Parity sense high gives even parity, low gives odd parity.
// - Each bit lasts sixteen periods of the sixteen-times transmit clock.
// - Buffer-empty rises once the holding buffer hands its character on.
// - Master clear sets buffer-empty, shifter-empty and the serial line high.
// - Master clear sets shifter-empty at once; the first transmit clock rise after it keeps it set unless a character moves.
module utx_top
  import utx_pkg::*;
(
  input wire logic clk, // System clock, 125 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic master_clear, // Master clear, active high.
  input wire logic tx_sixteenx_clock, // Transmit clock at sixteen times the bit rate.
  input wire logic [utx_pkg::DATA_W-1:0] tx_char_in, // Parallel character, bit 0 sent first.
  input wire logic holding_buffer_load_strobe_n, // Buffer load strobe, active low.
  input wire logic control_word_load, // Control word capture, active high.
  input wire logic parity_inhibit, // High drops the parity bit.
  input wire logic stop_count_select, // High selects 1.5 or 2 stop bits.
  input wire logic length_select_lo, // Length select, low bit.
  input wire logic length_select_hi, // Length select, high bit.
  input wire logic parity_sense_even, // High even parity, low odd.
  input wire logic [utx_pkg::ADDR_W-1:0] reg_addr, // Register byte address.
  input wire logic [utx_pkg::REG_W-1:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [utx_pkg::REG_W-1:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  output logic irq, // Interrupt, high while an unmasked status bit is set.
  output logic serial_tx_out, // Serial output line.
  output logic holding_buffer_empty_flag, // Holding buffer can take a character.
  output logic shifter_empty_flag, // Shifter has finished its last character.
  output logic parity_mismatch_flag // Parity error; no receiver here, so always low.
);
  import utx_pkg::*;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] hold_q, hold_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic strobe_n_prev_q;
  logic tclk_prev_q;
  logic req_q, req_d;
  logic hbe_q, hbe_d;
  logic shift_empty_q, shift_empty_d;
  logic shift_arm_q, shift_arm_d;
  logic serial_q;
  logic perr_q;
  logic [INT_W-1:0] int_stat_q, int_stat_d;
  logic [INT_W-1:0] int_mask_q, int_mask_d;
  logic irq_q;
  logic [REG_W-1:0] rdata_q, rdata_d;

  logic tick;
  logic strobe_rise;
  logic move;
  logic sh_busy;
  logic sh_ending;
  logic sh_line;
  logic frame_done;
  logic [FRAME_W-1:0] frame;
  logic [HALF_W-1:0] halves;

  // The transmit clock arrives as a plain synchronous input; only its rising
  // edges advance the frame, so it may run at any rate up to clk/2.
  assign tick = tx_sixteenx_clock && !tclk_prev_q;
  assign strobe_rise = holding_buffer_load_strobe_n && !strobe_n_prev_q;
  assign move = req_q && tick && (!sh_busy || sh_ending) && !master_clear;
  assign frame_done = tick && sh_ending && !move;
  assign frame = utx_frame(hold_q, ctrl_q);
  assign halves = utx_halves(ctrl_q);

  utx_shifter u_shifter (
    .clk(clk),
    .rst_n(rst_n),
    .clear(master_clear),
    .tick(tick),
    .load(move),
    .frame_in(frame),
    .halves_in(halves),
    .busy(sh_busy),
    .ending(sh_ending),
    .line(sh_line)
  );

  // ---------------------------------------------------------------------------
  // Holding buffer, control word and transfer request
  // ---------------------------------------------------------------------------
  always_comb begin
    hold_d = hold_q;
    ctrl_d = ctrl_q;
    req_d = req_q;
    if (!holding_buffer_load_strobe_n) begin
      hold_d = tx_char_in;
    end
    if (control_word_load) begin
      ctrl_d[CTRL_PAR_INH] = parity_inhibit;
      ctrl_d[CTRL_STOP_SEL] = stop_count_select;
      ctrl_d[CTRL_LEN_HI] = length_select_hi;
      ctrl_d[CTRL_LEN_LO] = length_select_lo;
      ctrl_d[CTRL_PAR_EVEN] = parity_sense_even;
    end
    if (move) begin
      req_d = 1'b0;
    end
    if (strobe_rise) begin
      req_d = 1'b1;
    end
    if (master_clear) begin
      req_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q <= '0;
      ctrl_q <= CTRL_RESET;
      req_q <= 1'b0;
      strobe_n_prev_q <= 1'b1;
      tclk_prev_q <= 1'b1;
    end else begin
      hold_q <= hold_d;
      ctrl_q <= ctrl_d;
      req_q <= req_d;
      strobe_n_prev_q <= holding_buffer_load_strobe_n;
      tclk_prev_q <= tx_sixteenx_clock;
    end
  end

  // ---------------------------------------------------------------------------
  // Status flags and serial output
  // ---------------------------------------------------------------------------
  always_comb begin
    hbe_d = hbe_q;
    shift_empty_d = shift_empty_q;
    shift_arm_d = shift_arm_q;
    if (move) begin
      hbe_d = 1'b1;
      shift_empty_d = 1'b0;
    end
    if (!holding_buffer_load_strobe_n) begin
      hbe_d = 1'b0;
    end
    if (frame_done) begin
      shift_empty_d = 1'b1;
    end
    // A character entering on that same tick drives the flag back low, as the shifter is busy again.
    if (shift_arm_q && tick) begin
      shift_empty_d = !move;
      shift_arm_d = 1'b0;
    end
    if (master_clear) begin
      hbe_d = 1'b1;
      shift_empty_d = 1'b1;
      shift_arm_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hbe_q <= 1'b1;
      shift_empty_q <= 1'b1;
      shift_arm_q <= 1'b0;
      serial_q <= 1'b1;
      perr_q <= 1'b0;
    end else begin
      hbe_q <= hbe_d;
      shift_empty_q <= shift_empty_d;
      shift_arm_q <= shift_arm_d;
      serial_q <= master_clear ? 1'b1 : sh_line;
      perr_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Register port and interrupt
  // ---------------------------------------------------------------------------
  // Writing a one clears a status bit, but a new event in the same cycle wins,
  // so software never loses an edge it is acknowledging.
  always_comb begin
    int_stat_d = int_stat_q;
    int_mask_d = int_mask_q;
    rdata_d = '0;
    if (reg_wr && reg_addr == ADDR_INT_STAT) begin
      int_stat_d = int_stat_q & ~reg_wdata[INT_W-1:0];
    end
    if (reg_wr && reg_addr == ADDR_INT_MASK) begin
      int_mask_d = reg_wdata[INT_W-1:0];
    end
    if (move) begin
      int_stat_d[INT_HBE] = 1'b1;
    end
    if (frame_done) begin
      int_stat_d[INT_DONE] = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
        ADDR_FLAGS: rdata_d[FLAG_W-1:0] = {req_q, sh_busy, shift_empty_q, hbe_q};
        ADDR_INT_STAT: rdata_d[INT_W-1:0] = int_stat_q;
        ADDR_INT_MASK: rdata_d[INT_W-1:0] = int_mask_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_stat_q <= '0;
      int_mask_q <= INT_MASK_RESET;
      irq_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      irq_q <= |(int_stat_d & int_mask_d);
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign serial_tx_out = serial_q;
  assign holding_buffer_empty_flag = hbe_q;
  assign shifter_empty_flag = shift_empty_q;
  assign parity_mismatch_flag = perr_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_strobe_rise;
    !holding_buffer_load_strobe_n ##1 holding_buffer_load_strobe_n;
  endsequence

  property p_hold_copy;
    @(posedge clk) disable iff (!rst_n)
    !holding_buffer_load_strobe_n |=> hold_q == $past(tx_char_in);
  endproperty
  a_hold_copy: assert property (p_hold_copy) else $error("holding buffer missed the character inputs");

  property p_request;
    @(posedge clk) disable iff (!rst_n)
    s_strobe_rise ##0 !master_clear |=> req_q;
  endproperty
  a_request: assert property (p_request) else $error("strobe rise did not raise a transfer request");

  property p_back_to_back;
    @(posedge clk) disable iff (!rst_n)
    req_q && tick && sh_ending && !master_clear |=> sh_busy && !shift_empty_q ##1 !serial_tx_out;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("pending character did not follow without a gap");

  property p_empty_after_frame;
    @(posedge clk) disable iff (!rst_n)
    sh_busy && !master_clear |=> !shifter_empty_flag || !$past(sh_busy) == 1'b0 && !sh_busy;
  endproperty
  a_empty_after_frame: assert property (p_empty_after_frame) else $error("shifter empty rose during a frame");

  property p_idle_high;
    @(posedge clk) disable iff (!rst_n)
    !sh_busy |=> serial_tx_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("serial line not high while idle");

  property p_parity_low;
    @(posedge clk) disable iff (!rst_n)
    ##1 !parity_mismatch_flag;
  endproperty
  a_parity_low: assert property (p_parity_low) else $error("parity error output not low");

  property p_ctrl_capture;
    @(posedge clk) disable iff (!rst_n)
    control_word_load |=> ctrl_q[CTRL_PAR_INH] == $past(parity_inhibit)
      && ctrl_q[CTRL_STOP_SEL] == $past(stop_count_select)
      && ctrl_q[CTRL_LEN_HI] == $past(length_select_hi) && ctrl_q[CTRL_LEN_LO] == $past(length_select_lo)
      && ctrl_q[CTRL_PAR_EVEN] == $past(parity_sense_even);
  endproperty
  a_ctrl_capture: assert property (p_ctrl_capture) else $error("control word not captured");

  property p_hbe_on_move;
    @(posedge clk) disable iff (!rst_n)
    move && holding_buffer_load_strobe_n |=> holding_buffer_empty_flag && req_q == 1'b0 || $past(strobe_rise);
  endproperty
  a_hbe_on_move: assert property (p_hbe_on_move) else $error("buffer empty not raised on transfer");

  property p_master_clear;
    @(posedge clk) disable iff (!rst_n)
    master_clear |=> holding_buffer_empty_flag && shifter_empty_flag ##1 serial_tx_out;
  endproperty
  a_master_clear: assert property (p_master_clear) else $error("master clear did not set flags and line");

  property p_load_clears;
    @(posedge clk) disable iff (!rst_n)
    !holding_buffer_load_strobe_n && !master_clear |=> !holding_buffer_empty_flag;
  endproperty
  a_load_clears: assert property (p_load_clears) else $error("buffer empty not cleared by a load");

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
    ##1 irq == |(int_stat_q & int_mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt does not follow masked status");

endmodule

// *** test/utx_rx_model.sv ***
// Serial receiver model that samples the transmitter line in mid-bit.
module utx_rx_model (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic line, // Serial line from the transmitter.
  input wire logic [3:0] last_bit, // Index of the first stop bit.
  output logic [11:0] bits_q, // Sampled frame, start bit in bit 0.
  output logic start_q, // Pulse on a start edge.
  output logic done_q // Pulse once the first stop bit is sampled.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q, act_q;
  logic [8:0] cnt_q;
  logic [3:0] k_q;
  // A bit lasts 32 clocks because the bench toggles the transmit clock on every clock.
  // Bits above the stop index stay one, so a whole frame compares as one word.
  always_ff @(posedge clk) begin
    start_q <= 1'b0;
    done_q <= 1'b0;
    prev_q <= line;
    if (!rst_n) begin
      act_q <= 1'b0;
      bits_q <= 12'hFFF;
    end else if (!act_q) begin
      if (prev_q && !line) begin
        act_q <= 1'b1;
        start_q <= 1'b1;
        cnt_q <= 9'h000;
        k_q <= 4'h0;
        bits_q <= 12'hFFF;
      end
    end else begin
      cnt_q <= cnt_q + 9'h001;
      if (cnt_q[4:0] == 5'h0F) begin
        bits_q[k_q] <= line;
        k_q <= k_q + 4'h1;
        if (k_q == last_bit) begin
          act_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule

// *** test/utx_top_tb.sv ***
// Self-checking bench for the transmitter, its control word and its registers.
module utx_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import utx_pkg::*;
  logic clk = 0, rst_n = 0, mc = 0, tclk = 0, ld_n = 1, cwl = 0, wr = 0, rd = 0;
  logic [4:0] cw = 5'h00;
  logic [7:0] ch = 8'h00;
  logic [3:0] ra = 4'h0, nb = 4'h7;
  logic [31:0] wd = 32'h0, rdata;
  logic irq, sout, hbe, txe, perr, rstart, rdone;
  logic [11:0] rbits;
  int err_count = 0, compares = 0, cyc = 0;
  always #4 clk = ~clk;
  always @(posedge clk) tclk <= ~tclk;
  utx_top utx_top_i (.clk(clk), .rst_n(rst_n), .master_clear(mc), .tx_sixteenx_clock(tclk),
    .tx_char_in(ch), .holding_buffer_load_strobe_n(ld_n), .control_word_load(cwl),
    .parity_inhibit(cw[4]), .stop_count_select(cw[3]), .length_select_lo(cw[1]),
    .length_select_hi(cw[2]), .parity_sense_even(cw[0]), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq(irq), .serial_tx_out(sout),
    .holding_buffer_empty_flag(hbe), .shifter_empty_flag(txe), .parity_mismatch_flag(perr));
  utx_rx_model utx_rx_model_i (.clk(clk), .rst_n(rst_n), .line(sout), .last_bit(nb),
    .bits_q(rbits), .start_q(rstart), .done_q(rdone));
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("Counts: compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tic(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Waits are bounded so a stuck flag shows as a mismatch, not a hang.
  task automatic wt(ref logic s);
    int i;
    for (i = 0; i < 2000 && s !== 1'b1; i++) @(posedge clk);
    if (i == 2000) chk(0, 1);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    wr <= 1;
    ra <= a;
    wd <= d;
    tic(1);
    wr <= 0;
    tic(1);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    rd <= 1;
    ra <= a;
    tic(1);
    rd <= 0;
    tic(1);
    chk(rdata, e);
  endtask
  task automatic set_ctrl(input logic [4:0] c);
    cw <= c;
    cwl <= 1;
    tic(1);
    cwl <= 0;
    tic(1);
  endtask
  task automatic send(input logic [7:0] d);
    ch <= d;
    ld_n <= 0;
    tic(1);
    ld_n <= 1;
    tic(1);
  endtask
  function automatic logic [11:0] frm(input logic [7:0] d, input logic [4:0] c);
    int n;
    logic [11:0] f;
    logic p;
    n = 5 + 2 * c[2] + c[1];
    f = 12'hFFE;
    p = ~c[0];
    for (int i = 0; i < n; i++) begin
      f[i+1] = d[i];
      p ^= d[i];
    end
    if (!c[4]) f[n+1] = p;
    return f;
  endfunction
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk(32'({sout, hbe, txe, perr, irq}), 32'h1C);
    rreg(ADDR_CTRL, 0);
    rreg(ADDR_FLAGS, 32'h3);
    rreg(ADDR_INT_MASK, 0);
    rreg(4'h2, 0);
  endtask
  task automatic t_modes();
    logic [4:0] c;
    logic [7:0] d;
    int n, h;
    time t0;
    for (int m = 0; m < 32; m++) begin
      c = 5'(m);
      d = 8'hA5 ^ 8'(m * 37);
      n = 5 + 2 * c[2] + c[1];
      h = 2 * (1 + n + (c[4] ? 0 : 1)) + (!c[3] ? 2 : (n == 5 ? 3 : 4));
      set_ctrl(c);
      rreg(ADDR_CTRL, 32'(c));
      nb <= 4'(n + (c[4] ? 0 : 1) + 1);
      send(d);
      wt(rstart);
      t0 = $time;
      wt(rdone);
      chk(32'(rbits), 32'(frm(d, c)));
      wt(txe);
      chk(32'(($time - t0) / 8), 32'(16 * h - 2));
      chk(32'(perr), 0);
    end
  endtask
  task automatic t_b2b();
    time t0;
    set_ctrl(5'h06);
    nb <= 4'hA;
    ch <= 8'h11;
    ld_n <= 0;
    tic(1);
    ch <= 8'h3C;
    tic(1);
    ld_n <= 1;
    tic(1);
    chk(32'(hbe), 0);
    wt(rstart);
    t0 = $time;
    chk(32'({hbe, txe}), 32'h2);
    send(8'hC3);
    chk(32'(hbe), 0);
    wt(rdone);
    chk(32'(rbits), 32'(frm(8'h3C, 5'h06)));
    wt(rstart);
    chk(32'(($time - t0) / 8), 352);
    chk(32'(txe), 0);
    wt(rdone);
    chk(32'(rbits), 32'(frm(8'hC3, 5'h06)));
    wt(txe);
  endtask
  task automatic t_irq();
    rreg(ADDR_INT_STAT, 32'h3);
    wreg(ADDR_INT_MASK, 32'h2);
    tic(1);
    chk(32'(irq), 1);
    rreg(ADDR_INT_MASK, 32'h2);
    wreg(ADDR_INT_STAT, 32'h2);
    tic(1);
    chk(32'(irq), 0);
    rreg(ADDR_INT_STAT, 32'h1);
    wreg(ADDR_INT_MASK, 32'h1);
    tic(1);
    chk(32'(irq), 1);
    wreg(ADDR_INT_STAT, 32'h1);
    tic(1);
    chk(32'(irq), 0);
    wreg(ADDR_CTRL, 32'hFFFFFFFF);
    rreg(ADDR_CTRL, 32'h6);
  endtask
  task automatic t_clear();
    send(8'h55);
    wt(rstart);
    tic(40);
    mc <= 1;
    tic(3);
    chk(32'({hbe, txe, sout}), 32'h7);
    mc <= 0;
    tic(400);
    chk(32'({hbe, txe, sout}), 32'h7);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    tic(3);
    rst_n <= 1;
    t_reset();
    t_modes();
    t_b2b();
    t_irq();
    t_clear();
    close_out();
  end
endmodule
